// file: src/adc_cfg_defines.svh
// Functional notes
// - every register is a 16-bit word, shifted most significant bit first
// - read-only identity at offset zero: version, branch nibbles, type byte
// - control word: mode, standby, coding, test, bandwidth, clock hold; documented defaults
// - global and per-channel status words are read-only, writes leave them unchanged
// - four-bit sync delay adds extra cycles before data-ready restarts, default zero
// - per-channel calibration control word and read-only calibration busy mailbox
// - per-channel impedance trim word, reset value 0x07
// - per-channel external offset, gain, phase words, host written, default zero
// - per-channel read-only offset, gain, phase words show applied core corrections
// - after calibration the internal words read back equal to external words
// - access is 8 address bits with direction msb, then 16 data bits msb first
// - direction one is write, zero is read
// - reset pin low or software reset bit one restores all registers
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH
`define ADDR_ID 7'h00
`define ADDR_CTRL 7'h01
`define ADDR_GSTAT 7'h02
`define ADDR_SWRST 7'h04
`define ADDR_TEST 7'h05
`define ADDR_SYNC 7'h06
`define ADDR_CHSEL 7'h0f
`define ADDR_CALCTL 7'h10
`define ADDR_CALMBX 7'h11
`define ADDR_CHSTAT 7'h12
`define ADDR_TRIM 7'h13
`define ADDR_EXTOFS 7'h20
`define ADDR_OFS 7'h21
`define ADDR_EXTGAIN 7'h22
`define ADDR_GAIN 7'h23
`define ADDR_EXTPHS 7'h24
`define ADDR_PHS 7'h25
`define CTRL_RESET 16'h0000
`define TEST_RESET 16'h0000
`define SYNC_RESET 16'h0000
`define CHSEL_RESET 16'h0000
`define TRIM_RESET 16'h0007
`define ZERO_WORD 16'h0000
`define SYNC_DELAY_MSB 3
`define CHSEL_MSB 1
`define SWRST_BIT 0
`define ADDR_BITS 8
`define DATA_BITS 16
`define DIR_BIT 7
`endif

// file: src/adc_cfg_pkg.sv
package adc_cfg_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b10,
      PH_DONE = 2'b11
   } phase_t;
endpackage

// file: src/adc_cfg_channel.sv
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
// ***********************************
// one converter channel's register set
// ***********************************
module adc_cfg_channel (
   input wire logic core_clk,
   input wire logic regReset,
   input wire logic wrEn,
   input wire logic [6:0] wrAddr,
   input wire adc_cfg_pkg::word_t wrData,
   input wire adc_cfg_pkg::word_t calBusyIn,
   input wire adc_cfg_pkg::word_t statusIn,
   input wire adc_cfg_pkg::word_t ofsApplied,
   input wire adc_cfg_pkg::word_t gainApplied,
   input wire adc_cfg_pkg::word_t phsApplied,
   input wire logic [6:0] rdAddr,
   output adc_cfg_pkg::word_t rdData,
   output adc_cfg_pkg::word_t calCtl,
   output adc_cfg_pkg::word_t trim,
   output adc_cfg_pkg::word_t extOfs,
   output adc_cfg_pkg::word_t extGain,
   output adc_cfg_pkg::word_t extPhs
);
   import adc_cfg_pkg::*;
   word_t calCtl_q, trim_q, extOfs_q, extGain_q, extPhs_q;
   // read-only words are never written here
   always_ff @(posedge core_clk) begin
      if (regReset) begin
         calCtl_q <= `ZERO_WORD;
         trim_q <= `TRIM_RESET;
         extOfs_q <= `ZERO_WORD;
         extGain_q <= `ZERO_WORD;
         extPhs_q <= `ZERO_WORD;
      end else if (wrEn) begin
         if (wrAddr == `ADDR_CALCTL) calCtl_q <= wrData;
         if (wrAddr == `ADDR_TRIM) trim_q <= wrData;
         if (wrAddr == `ADDR_EXTOFS) extOfs_q <= wrData;
         if (wrAddr == `ADDR_EXTGAIN) extGain_q <= wrData;
         if (wrAddr == `ADDR_EXTPHS) extPhs_q <= wrData;
      end
   end
   assign calCtl = calCtl_q;
   assign trim = trim_q;
   assign extOfs = extOfs_q;
   assign extGain = extGain_q;
   assign extPhs = extPhs_q;
   // readbacks show what the core applies; core copies external after cal
   assign rdData = (rdAddr == `ADDR_CALCTL) ? calCtl_q :
                   (rdAddr == `ADDR_CALMBX) ? calBusyIn :
                   (rdAddr == `ADDR_CHSTAT) ? statusIn :
                   (rdAddr == `ADDR_TRIM) ? trim_q :
                   (rdAddr == `ADDR_EXTOFS) ? extOfs_q :
                   (rdAddr == `ADDR_OFS) ? ofsApplied :
                   (rdAddr == `ADDR_EXTGAIN) ? extGain_q :
                   (rdAddr == `ADDR_GAIN) ? gainApplied :
                   (rdAddr == `ADDR_EXTPHS) ? extPhs_q :
                   (rdAddr == `ADDR_PHS) ? phsApplied : `ZERO_WORD;
endmodule // adc_cfg_channel

// file: src/adc_cfg_regmap.sv
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
// ***********************************
// serial register bank, sampled on core_clk
// ***********************************
module adc_cfg_regmap #(
   parameter int NUM_CH = 4,
   parameter logic [15:0] CHIP_IDENTIFICATION = 16'h0a51 // arbitrary identity value
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serialRst_n,
   input wire logic serClk,
   input wire logic chipSel_n,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   input wire adc_cfg_pkg::word_t globalStatusIn,
   input wire logic [NUM_CH*16-1:0] calBusyIn,
   input wire logic [NUM_CH*16-1:0] chStatusIn,
   input wire logic [NUM_CH*16-1:0] ofsApplied,
   input wire logic [NUM_CH*16-1:0] gainApplied,
   input wire logic [NUM_CH*16-1:0] phsApplied,
   output adc_cfg_pkg::word_t ctrlWord,
   output adc_cfg_pkg::word_t testWord,
   output logic [`SYNC_DELAY_MSB:0] syncDelay,
   output logic [NUM_CH*16-1:0] calCtlOut,
   output logic [NUM_CH*16-1:0] trimOut,
   output logic [NUM_CH*16-1:0] extOfsOut,
   output logic [NUM_CH*16-1:0] extGainOut,
   output logic [NUM_CH*16-1:0] extPhsOut
);
   import adc_cfg_pkg::*;
   // ***********************************
   // elaboration checks
   // ***********************************
   // the selector field is two bits wide, so further banks could never be reached
   if (NUM_CH != 4) begin : g_bad_ch
      $error("channel selector decodes exactly four channels");
   end
   // ***********************************
   // serial front end
   // ***********************************
   logic sclkPrev_q;
   logic swReset;
   logic regReset;
   phase_t phase_q, phase_d;
   logic [4:0] bitCnt_q;
   logic [`ADDR_BITS-1:0] addr_q;
   word_t shIn_q, shOut_q;
   logic miso_q, misoOe_q;
   logic rise, fall, csActive, lastAddrBit, lastDataBit, isWrite, wrStrobe;
   logic addrShift, dataShift;
   word_t rdWord, dataWord;
   assign regReset = rst | ~serialRst_n | swReset;
   assign rise = serClk & ~sclkPrev_q;
   assign fall = ~serClk & sclkPrev_q;
   assign csActive = ~chipSel_n;
   assign lastAddrBit = (phase_q == PH_ADDR) && rise && (bitCnt_q == 5'(`ADDR_BITS - 1));
   assign lastDataBit = (phase_q == PH_DATA) && rise && (bitCnt_q == 5'(`DATA_BITS - 1));
   assign isWrite = addr_q[`DIR_BIT];
   assign wrStrobe = lastDataBit && isWrite;
   assign addrShift = rise && (phase_q == PH_ADDR);
   assign dataShift = rise && (phase_q == PH_DATA);
   // the last data bit is still on the line at the strobe, so it joins here
   assign dataWord = {shIn_q[`DATA_BITS-2:0], mosi};
   always_comb begin
      phase_d = phase_q;
      unique case (phase_q)
         PH_IDLE: if (csActive) phase_d = PH_ADDR;
         PH_ADDR: if (lastAddrBit) phase_d = PH_DATA;
         PH_DATA: if (lastDataBit) phase_d = PH_DONE;
         PH_DONE: phase_d = PH_DONE;
      endcase
      if (!csActive) phase_d = PH_IDLE;
   end
   // serClk is only oversampled, so each edge is seen one core_clk late
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclkPrev_q <= 1'b0;
      end else begin
         sclkPrev_q <= serClk;
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst || !serialRst_n) begin
         phase_q <= PH_IDLE;
      end else begin
         phase_q <= phase_d;
      end
   end
   // bit counter restarts at the address to data boundary
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         bitCnt_q <= 5'h00;
      end else if (lastAddrBit) begin
         bitCnt_q <= 5'h00;
      end else if (addrShift || dataShift) begin
         bitCnt_q <= bitCnt_q + 5'h01;
      end
   end
   // address then data shift in msb first
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         addr_q <= 8'h00;
      end else if (addrShift) begin
         addr_q <= {addr_q[`ADDR_BITS-2:0], mosi};
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         shIn_q <= `ZERO_WORD;
      end else if (dataShift) begin
         shIn_q <= {shIn_q[`DATA_BITS-2:0], mosi};
      end
   end
   // ***********************************
   // read data path
   // ***********************************
   // the word is loaded one cycle after the address completes,
   // so the read mux already sees the full offset
   logic loadPending_q;
   logic shiftOut;
   assign shiftOut = fall && (phase_q == PH_DATA) && misoOe_q;
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         loadPending_q <= 1'b0;
      end else begin
         loadPending_q <= lastAddrBit;
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         shOut_q <= `ZERO_WORD;
      end else if (loadPending_q) begin
         shOut_q <= rdWord;
      end else if (shiftOut) begin
         shOut_q <= {shOut_q[`DATA_BITS-2:0], 1'b0};
      end
   end
   // idle level is high, matching the pull-up on the shared line
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         miso_q <= 1'b1;
      end else if (shiftOut && !loadPending_q) begin
         miso_q <= shOut_q[`DATA_BITS-1];
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst || !csActive) begin
         misoOe_q <= 1'b0;
      end else if (loadPending_q) begin
         misoOe_q <= ~isWrite;
      end else if (phase_q == PH_DONE) begin
         misoOe_q <= 1'b0;
      end
   end
   assign miso = miso_q;
   assign misoOe = misoOe_q;
   // ***********************************
   // common registers
   // ***********************************
   word_t ctrl_q, test_q, sync_q, chsel_q, swrst_q;
   logic [6:0] regAddr;
   logic [1:0] chIdx;
   logic hitId, hitCtrl, hitGstat, hitSwrst, hitTest, hitSync, hitChsel, hitChan;
   logic wrCtrl, wrTest, wrSync, wrChsel, wrSwrst;
   assign regAddr = addr_q[`DIR_BIT-1:0];
   assign chIdx = chsel_q[`CHSEL_MSB:0];
   assign swReset = swrst_q[`SWRST_BIT];
   assign hitId = (regAddr == `ADDR_ID);
   assign hitCtrl = (regAddr == `ADDR_CTRL);
   assign hitGstat = (regAddr == `ADDR_GSTAT);
   assign hitSwrst = (regAddr == `ADDR_SWRST);
   assign hitTest = (regAddr == `ADDR_TEST);
   assign hitSync = (regAddr == `ADDR_SYNC);
   assign hitChsel = (regAddr == `ADDR_CHSEL);
   assign hitChan = (regAddr >= `ADDR_CALCTL);
   // id and status offsets get no write enable at all
   assign wrCtrl = wrStrobe && hitCtrl;
   assign wrTest = wrStrobe && hitTest;
   assign wrSync = wrStrobe && hitSync;
   assign wrChsel = wrStrobe && hitChsel;
   assign wrSwrst = wrStrobe && hitSwrst;
   always_ff @(posedge core_clk) begin
      if (regReset) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_q <= dataWord;
      end
   end
   always_ff @(posedge core_clk) begin
      if (regReset) begin
         test_q <= `TEST_RESET;
      end else if (wrTest) begin
         test_q <= dataWord;
      end
   end
   // upper bits are not stored, so they read back zero
   always_ff @(posedge core_clk) begin
      if (regReset) begin
         sync_q <= `SYNC_RESET;
      end else if (wrSync) begin
         sync_q <= 16'(dataWord[`SYNC_DELAY_MSB:0]);
      end
   end
   always_ff @(posedge core_clk) begin
      if (regReset) begin
         chsel_q <= `CHSEL_RESET;
      end else if (wrChsel) begin
         chsel_q <= dataWord;
      end
   end
   // software reset self-clears: it pulses for one cycle then releases
   always_ff @(posedge core_clk) begin
      if (rst || !serialRst_n || swReset) begin
         swrst_q <= `ZERO_WORD;
      end else if (wrSwrst) begin
         swrst_q <= dataWord;
      end
   end
   assign ctrlWord = ctrl_q;
   assign testWord = test_q;
   assign syncDelay = sync_q[`SYNC_DELAY_MSB:0];
   // ***********************************
   // per-channel banks
   // ***********************************
   logic [NUM_CH*16-1:0] chRd;
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic chWr;
         assign chWr = wrStrobe && (chIdx == 2'(c));
         adc_cfg_channel u_ch (
            .core_clk(core_clk),
            .regReset(regReset),
            .wrEn(chWr),
            .wrAddr(regAddr),
            .wrData(dataWord),
            .calBusyIn(calBusyIn[c*16 +: 16]),
            .statusIn(chStatusIn[c*16 +: 16]),
            .ofsApplied(ofsApplied[c*16 +: 16]),
            .gainApplied(gainApplied[c*16 +: 16]),
            .phsApplied(phsApplied[c*16 +: 16]),
            .rdAddr(regAddr),
            .rdData(chRd[c*16 +: 16]),
            .calCtl(calCtlOut[c*16 +: 16]),
            .trim(trimOut[c*16 +: 16]),
            .extOfs(extOfsOut[c*16 +: 16]),
            .extGain(extGainOut[c*16 +: 16]),
            .extPhs(extPhsOut[c*16 +: 16])
         );
      end
   endgenerate
   // ***********************************
   // read selection
   // ***********************************
   word_t chSel, commonRd;
   assign chSel = chRd[chIdx*16 +: 16];
   // gaps between the common words read zero rather than alias a neighbour
   assign commonRd = hitId ? CHIP_IDENTIFICATION :
                     hitCtrl ? ctrl_q :
                     hitGstat ? globalStatusIn :
                     hitSwrst ? swrst_q :
                     hitTest ? test_q :
                     hitSync ? sync_q :
                     hitChsel ? chsel_q : `ZERO_WORD;
   assign rdWord = hitChan ? chSel : commonRd;
endmodule // adc_cfg_regmap

// file: bench/adc_cfg_regmap_sva.sv
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
// ***********************************
// port checker for the register bank
// ***********************************
module adc_cfg_regmap_sva #(
   parameter int NUM_CH = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serialRst_n,
   input wire logic serClk,
   input wire logic chipSel_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic misoOe,
   input wire adc_cfg_pkg::word_t ctrlWord,
   input wire adc_cfg_pkg::word_t testWord,
   input wire logic [`SYNC_DELAY_MSB:0] syncDelay,
   input wire logic [NUM_CH*16-1:0] trimOut
);
   logic clkPrev_q;
   logic dirBit_q;
   logic [4:0] riseCnt_q;
   logic [1:0] quiet_q;
   wire serRise = serClk && !clkPrev_q && !chipSel_n;
   // quiet_q keeps $changed from blaming writes for what a reset did
   always_ff @(posedge core_clk) begin
      clkPrev_q <= serClk;
      if (chipSel_n) riseCnt_q <= 5'h00;
      else if (serRise && riseCnt_q != 5'h1f) riseCnt_q <= riseCnt_q + 5'h01;
      if (serRise && riseCnt_q == 5'h00) dirBit_q <= mosi;
      if (rst || !serialRst_n) quiet_q <= 2'h0;
      else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ctrl_reset_a: assert property (!serialRst_n |=> ctrlWord == 16'h0000 &&
      testWord == 16'h0000 && syncDelay == 4'h0) else $error("config not cleared by reset pin");
   trim_reset_a: assert property (!serialRst_n |=> trimOut == {NUM_CH{16'h0007}})
      else $error("trim not restored by reset pin");
   idle_miso_a: assert property (chipSel_n [*3] |-> miso && !misoOe)
      else $error("serial output active while deselected");
   read_window_a: assert property (misoOe && !chipSel_n |-> riseCnt_q >= 5'h08)
      else $error("serial output driven during address");
   read_dir_a: assert property (misoOe && !chipSel_n |-> !dirBit_q)
      else $error("serial output driven on a write");
   cfg_stable_a: assert property (chipSel_n [*3] ##0 quiet_q == 2'h3 |->
      $stable(ctrlWord) && $stable(trimOut)) else $error("config moved outside a frame");
   test_write_a: assert property ($changed(testWord) && quiet_q == 2'h3 |-> riseCnt_q == 5'h18)
      else $error("test word changed before 24 bits");
   trim_write_a: assert property ($changed(trimOut) && quiet_q == 2'h3 |-> dirBit_q)
      else $error("trim changed by a read");
endmodule // adc_cfg_regmap_sva

bind adc_cfg_regmap adc_cfg_regmap_sva #(.NUM_CH(NUM_CH)) chk (.core_clk(core_clk), .rst(rst),
   .serialRst_n(serialRst_n), .serClk(serClk), .chipSel_n(chipSel_n), .mosi(mosi),
   .miso(miso), .misoOe(misoOe), .ctrlWord(ctrlWord), .testWord(testWord),
   .syncDelay(syncDelay), .trimOut(trimOut));

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
// ***********************************
// serial host: 4 core cycles per clock phase
// ***********************************
module spi_host_model (
   input wire logic core_clk,
   input wire logic misoLine,
   output logic serClk,
   output logic chipSel_n,
   output logic mosi
);
   import adc_cfg_pkg::*;
   initial begin
      serClk = 1'b0;
      chipSel_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // n below 24 cuts the frame short
   task automatic frame(input logic wr, input logic [6:0] a, input word_t d, input int n,
         output word_t r);
      logic [23:0] bits;
      bits = {wr, a, d};
      r = 16'h0000;
      chipSel_n = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         mosi = bits[i];
         half();
         serClk = 1'b1;
         if (i < 16) r[i] = misoLine;
         half();
         if (i > 0) serClk = 1'b0;
      end
      chipSel_n = 1'b1;
      half();
      // last fall after deselect; clock then stands still low
      serClk = 1'b0;
      mosi = ~mosi;
      // keep the last fall inside the deselected gap, apart from the next select
      half();
   endtask
endmodule // spi_host_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
   import adc_cfg_pkg::*;
   localparam logic [15:0] ID = 16'h5a3c; // arbitrary identity value
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic serialRst_n = 1'b1;
   logic calDone = 1'b0;
   logic serClk, chipSel_n, mosi, miso, misoOe;
   word_t ctrlWord, testWord, r;
   logic [3:0] syncDelay;
   logic [63:0] cal, trim, eo, eg, ep;
   int mismatches = 0;
   int checks_done = 0;
   logic [6:0] rwa [5] = '{7'h10, 7'h13, 7'h20, 7'h22, 7'h24};
   logic [6:0] ro [9] = '{7'h00, 7'h02, 7'h11, 7'h12, 7'h21, 7'h23, 7'h25, 7'h03, 7'h30};
   localparam logic [63:0] PRE = 64'h0a03_0a02_0a01_0a00;
   wire misoLine = misoOe ? miso : 1'b1;
   always #2 core_clk = ~core_clk;
   adc_cfg_regmap #(.NUM_CH(4), .CHIP_IDENTIFICATION(ID)) dut (.core_clk(core_clk), .rst(rst),
      .serialRst_n(serialRst_n), .serClk(serClk), .chipSel_n(chipSel_n), .mosi(mosi),
      .miso(miso), .misoOe(misoOe), .globalStatusIn(16'h6e01),
      .calBusyIn(64'hb003_b002_b001_b000), .chStatusIn(64'h5c03_5c02_5c01_5c00),
      .ofsApplied(calDone ? eo : PRE), .gainApplied(calDone ? eg : PRE),
      .phsApplied(calDone ? ep : PRE), .ctrlWord(ctrlWord), .testWord(testWord),
      .syncDelay(syncDelay), .calCtlOut(cal), .trimOut(trim), .extOfsOut(eo),
      .extGainOut(eg), .extPhsOut(ep));
   spi_host_model host (.core_clk(core_clk), .misoLine(misoLine), .serClk(serClk),
      .chipSel_n(chipSel_n), .mosi(mosi));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input word_t d);
      host.frame(1'b1, a, d, 24, r);
   endtask
   task automatic rdc(input logic [6:0] a, input word_t exp);
      host.frame(1'b0, a, 16'h0000, 24, r);
      check($sformatf("reg %h", a), r, exp);
   endtask
   task automatic t_defaults();
      rdc(7'h00, ID);
      rdc(7'h01, 16'h0000);
      rdc(7'h05, 16'h0000);
      rdc(7'h06, 16'h0000);
      rdc(7'h0f, 16'h0000);
      rdc(7'h13, 16'h0007);
      rdc(7'h22, 16'h0000);
   endtask
   task automatic t_readonly();
      foreach (ro[i]) wr(ro[i], 16'hffff);
      rdc(7'h00, ID);
      rdc(7'h02, 16'h6e01);
      rdc(7'h12, 16'h5c00);
      rdc(7'h21, 16'h0a00);
      rdc(7'h30, 16'h0000);
   endtask
   task automatic t_channels();
      for (int c = 0; c < 4; c++) begin
         wr(7'h0f, 16'(c));
         foreach (rwa[k]) wr(rwa[k], 16'h1000 * 16'(k + 1) + 16'(c));
      end
      for (int c = 0; c < 4; c++) begin
         wr(7'h0f, 16'(c));
         foreach (rwa[k]) rdc(rwa[k], 16'h1000 * 16'(k + 1) + 16'(c));
         rdc(7'h11, 16'hb000 + 16'(c));
         rdc(7'h25, 16'h0a00 + 16'(c));
         check("trim out", trim[c*16 +: 16], 16'h2000 + 16'(c));
         check("phase out", ep[c*16 +: 16], 16'h5000 + 16'(c));
         check("cal out", cal[c*16 +: 16], 16'h1000 + 16'(c));
         check("offset out", eo[c*16 +: 16], 16'h3000 + 16'(c));
         check("gain out", eg[c*16 +: 16], 16'h4000 + 16'(c));
      end
      calDone = 1'b1;
      rdc(7'h21, 16'h3003);
      rdc(7'h23, 16'h4003);
   endtask
   task automatic t_ctrl();
      wr(7'h01, 16'h2d95);
      wr(7'h05, 16'h0003);
      wr(7'h06, 16'hfffa);
      host.frame(1'b1, 7'h01, 16'h0000, 20, r);
      rdc(7'h01, 16'h2d95);
      rdc(7'h06, 16'h000a);
      check("test out", testWord, 16'h0003);
      check("sync out", {12'h000, syncDelay}, 16'h000a);
   endtask
   task automatic t_resets();
      wr(7'h04, 16'h0001);
      check("ctrl out", ctrlWord, 16'h0000);
      rdc(7'h04, 16'h0000);
      rdc(7'h13, 16'h0007);
      wr(7'h05, 16'h0002);
      serialRst_n = 1'b0;
      @(posedge core_clk);
      #1;
      serialRst_n = 1'b1;
      @(posedge core_clk);
      #1;
      check("test out", testWord, 16'h0000);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_defaults();
      t_readonly();
      t_channels();
      t_ctrl();
      t_resets();
      stop_test();
   end
endmodule // tb
